// ---- logic/timer_compare_pwm_channels.sv ----
// two-channel 16-bit timer with output compare and pwm, plain register port
`timescale 1ns/10ps
//
// Operation
// - unbuffered channel value is one register, written directly, effective at once
// - compare fires only when counter equals stored channel value
// - channel compare request raised at the match ending the pulse
// - overflow request raised when counter reaches modulo value
// - link bit in channel zero control pairs channels onto pin zero
// - linked: channel zero first, after each overflow last written channel rules
// - linked: channel zero control governs, channel one control ignored, pin one released
// - toggle on overflow flips pin at each modulo match without a compare on the same tick
// - pulse runs from overflow to compare, compare drives opposite level
// - modulo 0x00FF undivided gives 256 clock period
// - value 0x0080 in 8-bit period gives half duty, single-count steps
// - buffered: written channel governs width from next period
// - mode select 0:1 unbuffered, 1:0 buffered
// - compare action 1:0 clears pin, 1:1 sets pin
// - toggle on overflow cleared gives 0% duty
// - full duty force with toggle on overflow holds 100% duty
// - at modulo, overflow flag sets and counter restarts from zero next tick
// - channel flag set on compare, requests interrupt when enabled
// - halt freezes counting, counter reset clears counter and prescaler, reads zero
module timer_compare_pwm_channels
   import timer_pwm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [DATA_W-1:0] rdata,
   output logic                   channel_zero_pin_o,
   output logic                   channel_zero_pin_oe_n,
   output logic                   channel_one_pin_o,
   output logic                   channel_one_pin_oe_n,
   output logic                   overflow_irq,
   output logic      [1:0]        channel_irq
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt_r;
      logic [CNT_W-1:0] modv_r;
      logic [CNT_W-1:0] val0_r;
      logic [CNT_W-1:0] val1_r;
      logic [7:0]       hi_buf_r;
      logic             mod_inh_r;
      logic             ovf_ie_r;
      logic             halt_r;
      logic [2:0]       ps_r;
      logic             ovf_flag_r;
      logic             ovf_arm_r;
      logic [6:0]       ctl0_r;
      logic [6:0]       ctl1_r;
      logic [1:0]       chf_r;
      logic [1:0]       charm_r;
      logic             active_r;
      logic             last_wr_r;
      logic             link_d_r;
      logic [PRE_W-1:0] pre_r;
      logic [7:0]       rdata_r;
   } tmr_state_t;

   tmr_state_t       s;
   tmr_state_t       n;
   logic             tick;
   logic             ovf_ev;
   logic             link;
   logic [CNT_W-1:0] cmp_val0;
   logic [CNT_W-1:0] cnt_inc;
   logic             match0;
   logic             match1;
   logic             drive0;
   logic             drive1;
   logic             pin0;
   logic             pin1;
   logic [PRE_W-1:0] pmask;

   function automatic logic [PRE_W-1:0] pre_mask(input logic [2:0] ps);
      logic [6:0] t;
      t = (7'h01 << ps) - 7'h01;
      return t[PRE_W-1:0];
   endfunction : pre_mask

   // channel drives its pin in a compare or pwm mode with a pin action
   function automatic logic out_mode(input logic [6:0] ctl);
      return (ctl[CH_MSB] | ctl[CH_MSA]) && (ctl[CH_ELSB:CH_ELSA] != ACT_NONE);
   endfunction : out_mode

   always_comb
   begin
      n = s;
      pmask = pre_mask(s.ps_r);
      tick = !s.halt_r && (s.ps_r != PS_OFF) && ((s.pre_r & pmask) == pmask);
      ovf_ev = tick && (s.cnt_r == s.modv_r);
      cnt_inc = ovf_ev ? CNT_RST : s.cnt_r + 16'h0001;
      link = s.ctl0_r[CH_MSB];
      cmp_val0 = (link && s.active_r) ? s.val1_r : s.val0_r;
      drive0 = out_mode(s.ctl0_r);
      drive1 = out_mode(s.ctl1_r) && !link;
      match0 = tick && (cnt_inc == cmp_val0) && drive0;
      match1 = tick && (cnt_inc == s.val1_r) && drive1 && !link;
      n.rdata_r = BYTE_RST;
      n.link_d_r = link;

      // prescaler and counter
      if (!s.halt_r && (s.ps_r != PS_OFF))
      begin
         n.pre_r = s.pre_r + 6'h01;
      end
      if (tick)
      begin
         n.cnt_r = cnt_inc;
      end

      // linked pair hand-over at overflow
      if (link && !s.link_d_r)
      begin
         n.active_r = 1'b0;
         n.last_wr_r = 1'b0;
      end
      else if (link && ovf_ev)
      begin
         n.active_r = s.last_wr_r;
      end

      // register reads
      if (rd)
      begin
         unique case (addr)
            OFS_TSC     :
            begin
               n.rdata_r = {s.ovf_flag_r, s.ovf_ie_r, s.halt_r, 2'h0, s.ps_r};
               n.ovf_arm_r = s.ovf_flag_r;
            end
            OFS_CNT_HI  : n.rdata_r = s.cnt_r[15:8];
            OFS_CNT_LO  : n.rdata_r = s.cnt_r[7:0];
            OFS_MOD_HI  : n.rdata_r = s.modv_r[15:8];
            OFS_MOD_LO  : n.rdata_r = s.modv_r[7:0];
            OFS_CH0_CTL :
            begin
               n.rdata_r = {s.chf_r[0], s.ctl0_r};
               n.charm_r[0] = s.chf_r[0];
            end
            OFS_CH0_HI  : n.rdata_r = s.val0_r[15:8];
            OFS_CH0_LO  : n.rdata_r = s.val0_r[7:0];
            OFS_CH1_CTL :
            begin
               n.rdata_r = {s.chf_r[1], s.ctl1_r};
               n.charm_r[1] = s.chf_r[1];
            end
            OFS_CH1_HI  : n.rdata_r = s.val1_r[15:8];
            OFS_CH1_LO  : n.rdata_r = s.val1_r[7:0];
            default     : n.rdata_r = BYTE_RST;
         endcase
      end

      // register writes
      if (wr)
      begin
         unique case (addr)
            OFS_TSC     :
            begin
               n.ovf_ie_r = wdata[TSC_IE];
               n.halt_r = wdata[TSC_HALT];
               n.ps_r = wdata[TSC_PS_HI:0];
               if (!wdata[TSC_FLAG] && s.ovf_arm_r)
               begin
                  n.ovf_flag_r = 1'b0;
               end
               n.ovf_arm_r = 1'b0;
               if (wdata[TSC_TRST])
               begin
                  n.cnt_r = CNT_RST;
                  n.pre_r = PRE_RST;
               end
            end
            OFS_MOD_HI  :
            begin
               n.hi_buf_r = wdata;
               n.mod_inh_r = 1'b1;
            end
            OFS_MOD_LO  :
            begin
               n.modv_r = {s.hi_buf_r, wdata};
               n.mod_inh_r = 1'b0;
            end
            OFS_CH0_CTL :
            begin
               n.ctl0_r = wdata[6:0];
               if (!wdata[CH_FLAG] && s.charm_r[0])
               begin
                  n.chf_r[0] = 1'b0;
               end
               n.charm_r[0] = 1'b0;
            end
            OFS_CH1_CTL :
            begin
               n.ctl1_r = {wdata[CH_IE], 1'b0, wdata[CH_MSA:0]};
               if (!wdata[CH_FLAG] && s.charm_r[1])
               begin
                  n.chf_r[1] = 1'b0;
               end
               n.charm_r[1] = 1'b0;
            end
            OFS_CH0_HI,
            OFS_CH1_HI  : n.hi_buf_r = wdata;
            OFS_CH0_LO  :
            begin
               n.val0_r = {s.hi_buf_r, wdata};
               n.last_wr_r = 1'b0;
            end
            OFS_CH1_LO  :
            begin
               n.val1_r = {s.hi_buf_r, wdata};
               n.last_wr_r = 1'b1;
            end
            default     : n.hi_buf_r = s.hi_buf_r;
         endcase
      end

      // hardware sets win over software clears
      if (ovf_ev && !s.mod_inh_r)
      begin
         n.ovf_flag_r = 1'b1;
         n.ovf_arm_r = 1'b0;
      end
      if (match0)
      begin
         n.chf_r[0] = 1'b1;
         n.charm_r[0] = 1'b0;
      end
      if (match1)
      begin
         n.chf_r[1] = 1'b1;
         n.charm_r[1] = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
         s.modv_r <= MOD_RST;
         s.halt_r <= HALT_RST;
         s.ps_r <= PS_RST;
         s.ctl0_r <= CTL_RST;
         s.ctl1_r <= CTL_RST;
         s.val0_r <= VAL_RST;
         s.val1_r <= VAL_RST;
      end
      else if (ce)
      begin
         s <= n;
      end
   end

   pwm_pin_unit u_pin0 (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .tick  (tick),
      .ovf   (ovf_ev),
      .match (match0),
      .drive (drive0),
      .act   (s.ctl0_r[CH_ELSB:CH_ELSA]),
      .tov   (s.ctl0_r[CH_TOV]),
      .full  (s.ctl0_r[CH_MAX]),
      .pin   (pin0)
   );

   pwm_pin_unit u_pin1 (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .tick  (tick),
      .ovf   (ovf_ev),
      .match (match1),
      .drive (drive1),
      .act   (s.ctl1_r[CH_ELSB:CH_ELSA]),
      .tov   (s.ctl1_r[CH_TOV]),
      .full  (s.ctl1_r[CH_MAX]),
      .pin   (pin1)
   );

   assign rdata                 = s.rdata_r;
   assign channel_zero_pin_o    = pin0;
   assign channel_zero_pin_oe_n = ~drive0;
   assign channel_one_pin_o     = pin1;
   assign channel_one_pin_oe_n  = ~drive1;
   assign overflow_irq          = s.ovf_flag_r & s.ovf_ie_r;
   assign channel_irq[0]        = s.chf_r[0] & s.ctl0_r[CH_IE];
   assign channel_irq[1]        = s.chf_r[1] & s.ctl1_r[CH_IE] & ~link;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_wrap_step;
      ce && ovf_ev;
   endsequence

   sequence s_restart;
      s.cnt_r == CNT_RST;
   endsequence

   property p_wrap;
      s_wrap_step |=> s_restart;
   endproperty
   a_wrap : assert property (p_wrap) else $error("counter did not restart after modulo");

   property p_ovf_flag;
      ce && ovf_ev && !s.mod_inh_r |=> s.ovf_flag_r && (overflow_irq == s.ovf_ie_r);
   endproperty
   a_ovf_flag : assert property (p_ovf_flag) else $error("overflow flag not set");

   property p_halt;
      ce && s.halt_r && !(wr && addr == OFS_TSC) |=> $stable(s.cnt_r) && $stable(s.pre_r);
   endproperty
   a_halt : assert property (p_halt) else $error("counter moved while halted");

   property p_trst;
      ce && wr && addr == OFS_TSC && wdata[TSC_TRST]
         |=> s.cnt_r == CNT_RST && s.pre_r == PRE_RST;
   endproperty
   a_trst : assert property (p_trst) else $error("counter reset did not clear");

   property p_val0;
      ce && wr && addr == OFS_CH0_LO |=> s.val0_r == {$past(s.hi_buf_r), $past(wdata)};
   endproperty
   a_val0 : assert property (p_val0) else $error("channel value not written");

   property p_flag0;
      ce && match0 |=> s.chf_r[0] && (channel_irq[0] == s.ctl0_r[CH_IE]);
   endproperty
   a_flag0 : assert property (p_flag0) else $error("channel flag missed");

   property p_active;
      ce && link && s.link_d_r && ovf_ev |=> s.active_r == $past(s.last_wr_r);
   endproperty
   a_active : assert property (p_active) else $error("linked hand-over wrong");

   property p_link_pin;
      link |-> channel_one_pin_oe_n && !channel_irq[1];
   endproperty
   a_link_pin : assert property (p_link_pin) else $error("pin one driven while linked");

   property p_full;
      ce && tick && drive0 && s.ctl0_r[CH_MAX] && s.ctl0_r[CH_TOV]
         |=> channel_zero_pin_o == !$past(s.ctl0_r[CH_ELSA]);
   endproperty
   a_full : assert property (p_full) else $error("full duty not held");

   property p_zero;
      ce && tick && drive0 && !s.ctl0_r[CH_TOV] && !match0 |=> $stable(channel_zero_pin_o);
   endproperty
   a_zero : assert property (p_zero) else $error("pin moved without toggle");

   property p_clear;
      ce && match0 && !s.ctl0_r[CH_MAX] && s.ctl0_r[CH_ELSB:CH_ELSA] == ACT_CLEAR
         |=> !channel_zero_pin_o;
   endproperty
   a_clear : assert property (p_clear) else $error("compare did not clear pin");

endmodule : timer_compare_pwm_channels

// ---- inc/timer_pwm_pkg.sv ----
// constants and register layout for the two-channel compare and pwm timer
package timer_pwm_pkg;

   localparam int         ADDR_W       = 4;
   localparam int         DATA_W       = 8;
   localparam int         CNT_W        = 16;
   localparam int         PRE_W        = 6;

   // register offsets
   localparam logic [3:0] OFS_TSC      = 4'h0;
   localparam logic [3:0] OFS_CNT_HI   = 4'h1;
   localparam logic [3:0] OFS_CNT_LO   = 4'h2;
   localparam logic [3:0] OFS_MOD_HI   = 4'h3;
   localparam logic [3:0] OFS_MOD_LO   = 4'h4;
   localparam logic [3:0] OFS_CH0_CTL  = 4'h5;
   localparam logic [3:0] OFS_CH0_HI   = 4'h6;
   localparam logic [3:0] OFS_CH0_LO   = 4'h7;
   localparam logic [3:0] OFS_CH1_CTL  = 4'h8;
   localparam logic [3:0] OFS_CH1_HI   = 4'h9;
   localparam logic [3:0] OFS_CH1_LO   = 4'hA;

   // timer_control_status fields
   localparam int         TSC_FLAG     = 7;
   localparam int         TSC_IE       = 6;
   localparam int         TSC_HALT     = 5;
   localparam int         TSC_TRST     = 4;
   localparam int         TSC_PS_HI    = 2;

   // channel control fields
   localparam int         CH_FLAG      = 7;
   localparam int         CH_IE        = 6;
   localparam int         CH_MSB       = 5;
   localparam int         CH_MSA       = 4;
   localparam int         CH_ELSB      = 3;
   localparam int         CH_ELSA      = 2;
   localparam int         CH_TOV       = 1;
   localparam int         CH_MAX       = 0;

   // encodings
   localparam logic [1:0] MODE_UNBUF   = 2'h1;
   localparam logic [1:0] MODE_BUF     = 2'h2;
   localparam logic [1:0] ACT_NONE     = 2'h0;
   localparam logic [1:0] ACT_TOGGLE   = 2'h1;
   localparam logic [1:0] ACT_CLEAR    = 2'h2;
   localparam logic [1:0] ACT_SET      = 2'h3;
   localparam logic [2:0] PS_OFF       = 3'h7;

   // values after reset
   localparam logic [15:0] CNT_RST     = 16'h0000;
   localparam logic [15:0] MOD_RST     = 16'hFFFF;
   localparam logic [15:0] VAL_RST     = 16'h0000;
   localparam logic        HALT_RST    = 1'b1;
   localparam logic [2:0]  PS_RST      = 3'h0;
   localparam logic [6:0]  CTL_RST     = 7'h00;
   localparam logic [5:0]  PRE_RST     = 6'h00;
   localparam logic [7:0]  BYTE_RST    = 8'h00;

endpackage : timer_pwm_pkg

// ---- logic/pwm_pin_unit.sv ----
// output level logic of one compare channel pin
`timescale 1ns/10ps
module pwm_pin_unit
   import timer_pwm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       tick,
   input  wire logic       ovf,
   input  wire logic       match,
   input  wire logic       drive,
   input  wire logic [1:0] act,
   input  wire logic       tov,
   input  wire logic       full,
   output logic            pin
);

   typedef struct packed {
      logic pin_r;
   } pin_state_t;

   pin_state_t s;
   pin_state_t n;

   always_comb
   begin
      n = s;
      if (tick && drive)
      begin
         if (full && tov)
         begin
            n.pin_r = ~act[0];
         end
         else if (match)
         begin
            unique case (act)
               ACT_TOGGLE : n.pin_r = ~s.pin_r;
               ACT_CLEAR  : n.pin_r = 1'b0;
               ACT_SET    : n.pin_r = 1'b1;
               ACT_NONE   : n.pin_r = s.pin_r;
            endcase
         end
         else if (ovf && tov)
         begin
            n.pin_r = ~s.pin_r;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else if (ce)
      begin
         s <= n;
      end
   end

   assign pin = s.pin_r;

endmodule : pwm_pin_unit

// ---- dv/pin_load_model.sv ----
// external load on a channel pin, measures pulse high time and period
`timescale 1ns/10ps
module pin_load_model
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic pin_o,
   input  wire logic pin_oe_n,
   output int        hi_len,
   output int        per_len,
   output int        edges,
   output logic      level
);
   logic prev;
   int   hi_cnt;
   int   per_cnt;

   // released pin falls to the pull-down level
   assign level = pin_oe_n ? 1'b0 : pin_o;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prev    <= 1'b0;
         hi_cnt  <= 0;
         per_cnt <= 0;
         hi_len  <= 0;
         per_len <= 0;
         edges   <= 0;
      end
      else
      begin
         prev    <= level;
         per_cnt <= per_cnt + 1;
         hi_cnt  <= level ? hi_cnt + 1 : 0;
         // period from rise to rise, width from rise to fall
         if (level && !prev)
         begin
            per_len <= per_cnt;
            per_cnt <= 1;
            edges   <= edges + 1;
         end
         if (!level && prev)
         begin
            hi_len <= hi_cnt;
            edges  <= edges + 1;
         end
      end
   end
endmodule : pin_load_model

// ---- dv/timer_compare_pwm_channels_tb.sv ----
// self-checking bench for the compare and pwm timer
`timescale 1ns/10ps
module timer_compare_pwm_channels_tb
   import timer_pwm_pkg::*;
;
   logic              clk   = 1'b0;
   logic              rst   = 1'b1;
   logic              ce    = 1'b1;
   logic [ADDR_W-1:0] addr  = 4'h0;
   logic [DATA_W-1:0] wdata = 8'h00;
   logic              wr    = 1'b0;
   logic              rd    = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              p0_o;
   logic              p0_oe_n;
   logic              p1_o;
   logic              p1_oe_n;
   logic              overflow_irq;
   logic [1:0]        channel_irq;
   int                hi_len;
   int                per_len;
   int                edges;
   logic              level;
   int                hi_len1;
   int                per_len1;
   logic              level1;
   int                bad_count = 0;
   int                n_checks  = 0;
   logic [7:0]        tmp;
   logic [7:0]        tmp2;
   int                e0;
   logic [7:0]        t_ctl [5] = '{8'h1A, 8'h1A, 8'h1A, 8'h1E, 8'h1A};
   logic [15:0]       t_val [5] = '{16'h0080, 16'h0081, 16'h0001, 16'h0040, 16'h0080};
   logic [2:0]        t_ps  [5] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1};
   int                t_hi  [5] = '{128, 129, 1, 192, 256};
   int                t_per [5] = '{256, 256, 256, 256, 512};

   always #2 clk = ~clk;

   timer_compare_pwm_channels timer_compare_pwm_channels_i (
      .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .channel_zero_pin_o(p0_o), .channel_zero_pin_oe_n(p0_oe_n),
      .channel_one_pin_o(p1_o), .channel_one_pin_oe_n(p1_oe_n),
      .overflow_irq(overflow_irq), .channel_irq(channel_irq));

   pin_load_model pin_load_model_i (
      .clk(clk), .rst(rst), .pin_o(p0_o), .pin_oe_n(p0_oe_n),
      .hi_len(hi_len), .per_len(per_len), .edges(edges), .level(level));

   pin_load_model pin_one_load (
      .clk(clk), .rst(rst), .pin_o(p1_o), .pin_oe_n(p1_oe_n),
      .hi_len(hi_len1), .per_len(per_len1), .edges(), .level(level1));

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   task wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task rd_chk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      chk(d, exp);
   endtask : rd_chk

   task wr16(input logic [3:0] a_hi, input logic [15:0] v);
      wr_reg(a_hi, v[15:8]);
      wr_reg(4'(a_hi + 4'h1), v[7:0]);
   endtask : wr16

   // waits for k full pulses seen by the load, bounded
   task wait_pulses(input int k);
      int start;
      int n;
      start = edges;
      n = 0;
      while (edges < start + 2 * k && n < 5000)
      begin
         @(posedge clk);
         n++;
      end
      chk(n < 5000, 1);
   endtask : wait_pulses

   // setup order: halt and reset, modulo, width, mode bits, release
   task pwm(input logic [7:0] ctl, input logic [15:0] val, input logic [2:0] ps,
            input logic [7:0] timer_control_status);
      wr_reg(OFS_TSC, 8'h30);
      wr16(OFS_MOD_HI, 16'h00FF);
      wr16(OFS_CH0_HI, val);
      wr_reg(OFS_CH0_CTL, ctl);
      wr_reg(OFS_TSC, timer_control_status | {5'h00, ps});
   endtask : pwm

   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   initial
   begin
      #(4 * 60000);
      bad_count++;
      give_verdict;
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_chk(OFS_TSC, 8'h20);
      rd_chk(OFS_MOD_HI, 8'hFF);
      rd_chk(OFS_MOD_LO, 8'hFF);
      rd_chk(OFS_CH0_CTL, 8'h00);
      rd_chk(4'hF, 8'h00);
      chk(p0_oe_n, 1'b1);
      wr_reg(OFS_TSC, 8'h00);
      repeat (20) @(posedge clk);
      wr_reg(OFS_TSC, 8'h20);
      rd_reg(OFS_CNT_LO, tmp);
      repeat (10) @(posedge clk);
      rd_reg(OFS_CNT_LO, tmp2);
      chk(tmp2, tmp);
      chk(tmp != 8'h00, 1);
      wr_reg(OFS_TSC, 8'h30);
      rd_chk(OFS_CNT_LO, 8'h00);
      rd_chk(OFS_TSC, 8'h20);
      // clock enable low drops a write that would release the halt
      ce <= 1'b0;
      wr_reg(OFS_TSC, 8'h00);
      ce <= 1'b1;
      rd_chk(OFS_TSC, 8'h20);
      for (int i = 0; i < 5; i++)
      begin
         pwm(t_ctl[i], t_val[i], t_ps[i], 8'h00);
         wait_pulses(3);
         chk(hi_len, t_hi[i]);
         chk(per_len, t_per[i]);
      end
      // shorter width written once the compare has ended the pulse
      @(negedge level);
      wr16(OFS_CH0_HI, 16'h0020);
      wait_pulses(3);
      chk(hi_len, 64);
      // longer width written once the overflow has started the pulse
      @(posedge level);
      wr16(OFS_CH0_HI, 16'h0060);
      wait_pulses(3);
      chk(hi_len, 192);
      wr16(OFS_CH1_HI, 16'h0040);
      wr_reg(OFS_CH1_CTL, 8'h5A);
      pwm(8'h5A, 16'h0080, 3'h0, 8'h40);
      wait_pulses(3);
      chk(overflow_irq, 1'b1);
      chk(channel_irq, 2'b11);
      chk(hi_len1, 64);
      chk(per_len1, 256);
      rd_chk(OFS_TSC, 8'hC0);
      wr_reg(OFS_TSC, 8'h40);
      #1;
      chk(overflow_irq, 1'b0);
      pwm(8'h58, 16'h0080, 3'h0, 8'h00);
      repeat (300) @(posedge clk);
      e0 = edges;
      repeat (600) @(posedge clk);
      chk(edges, e0);
      chk(level, 1'b0);
      pwm(8'h5B, 16'h0080, 3'h0, 8'h00);
      repeat (300) @(posedge clk);
      e0 = edges;
      repeat (600) @(posedge clk);
      chk(edges, e0);
      chk(level, 1'b1);
      pwm(8'h2A, 16'h0080, 3'h0, 8'h00);
      wait_pulses(2);
      chk(hi_len, 128);
      chk(p1_oe_n, 1'b1);
      chk(level1, 1'b0);
      wr_reg(OFS_CH1_CTL, 8'h1E);
      wr16(OFS_CH1_HI, 16'h0040);
      wait_pulses(3);
      chk(hi_len, 64);
      wr16(OFS_CH0_HI, 16'h0060);
      wait_pulses(3);
      chk(hi_len, 96);
      chk(channel_irq[1], 1'b0);
      chk(p1_oe_n, 1'b1);
      give_verdict;
   end
endmodule : timer_compare_pwm_channels_tb
